//--- iww_ctrl_map.vh
// register map, field positions, reset values and timing counts of the interrupt, wake and watchdog block
`ifndef IWW_CTRL_MAP_VH
`define IWW_CTRL_MAP_VH

// register indices; byte address is four times the index
`define IWW_IDX_STATUS 8'h03
`define IWW_IDX_IRQ_CONTROL 8'h0B
`define IWW_IDX_PERIPH_FLAG 8'h0C
`define IWW_IDX_OPTION 8'h81
`define IWW_IDX_PERIPH_ENABLE 8'h8C

// irq_control_reg fields
`define IWW_IC_GIE 7
`define IWW_IC_PEIE 6
`define IWW_IC_TOIE 5
`define IWW_IC_EXTE 4
`define IWW_IC_PCE 3
`define IWW_IC_TOIF 2
`define IWW_IC_EXTF 1
`define IWW_IC_PCF 0
`define IWW_IC_RESET 8'h00

// option_control fields
`define IWW_OPT_EDGE 6
`define IWW_OPT_PSA 3
`define IWW_OPT_PS_HI 2
`define IWW_OPT_PS_LO 0
`define IWW_OPT_RESET 8'hFF

// peripheral flag and enable bit of the converter
`define IWW_PF_CONV 0
`define IWW_PF_RESET 8'h00
`define IWW_PE_RESET 8'h00

// status fields
`define IWW_ST_TO 4
`define IWW_ST_PD 3
`define IWW_ST_SLEEP 0

// interrupt vector
`define IWW_VECTOR 13'h0004

// timing
`define IWW_CLK_PERIOD_PS 4000
`define IWW_WDT_TIMEOUT_MS 18
// 18 ms at 4 ns per clock, sized to the 23-bit watchdog counter
`define IWW_WDT_CYC 23'h44_AA20
`define IWW_INSTR_CLKS 4
`define IWW_IRQ_LAT_TICKS 3

`endif

//--- iww_ctrl.v
// interrupt gathering, watchdog and power-down control with an AHB-Lite register slave
// Summary of operation
// - each source flag sets on its event regardless of any enable bit
// - global enable gates unmasked sources; pending enabled source requests entry at once
// - every reset clears the global enable
// - return-from-interrupt sets the global enable again
// - entry clears global enable, core pushes return address, vector 0004h
// - external event to vector takes three or four instruction cycles
// - converter flag and enable live in peripheral registers, gated by peripheral enable
// - timer rollover sets flag bit 2; bit 5 enables it
// - external pin edge selected by option bit 6 sets flag bit 1; bit 4 enables
// - enabled external edge wakes from power-down; global enable decides vectoring
// - change on any of three monitored pins sets flag bit 0; bit 3 enables
// - only the return address is saved on entry, nothing else
// - watchdog runs in power-down; time-out clears status, resets or wakes
// - configuration bit clear disables the watchdog while it stays clear
// - base time-out 18 ms, optional prescaler extends it up to 1:128
// - clear-watchdog and power-down instructions clear counter and prescaler
// - power-down entry clears watchdog, clears powerdown status, sets timeout status, holds pins
// - power-down ends on reset pin, watchdog, or enabled interrupt source
// - during power-down the timer cannot wake; the converter may wake only on its own clock
// - wake ignores global enable; with it set the core vectors afterwards
// - power-down with an enabled pending flag is a no-operation
`timescale 1ns/1ps
`default_nettype none
`include "iww_ctrl_map.vh"

module iww_ctrl #(
  parameter [22:0] WDT_BASE_CYC = `IWW_WDT_CYC
) (
  input wire clk,
  input wire rst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // core side
  input wire return_from_irq_instr,
  input wire clear_watchdog_instr,
  input wire sleep_instr,
  input wire master_reset_pin_evt,
  input wire watchdog_enable_cfg,
  output reg irq_take,
  output reg [12:0] irq_vector,
  output reg core_sleeping,
  output reg wake_pulse,
  output reg wdt_reset_req,
  output wire hold_pins,
  output wire osc_stop,
  // event sources
  input wire timer_ovf_evt,
  input wire ext_irq_pin,
  input wire [2:0] change_pins,
  input wire conv_done_evt,
  input wire conv_rc_clock
);

  // bus slave never stalls and always answers okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  reg [7:0] irq_control_q;
  reg [7:0] option_q;
  reg [7:0] periph_flag_q;
  reg [7:0] periph_enable_q;
  reg to_q;
  reg pd_q;

  // ---------------- synchronisers and detectors
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_prev_q;
  reg [2:0] chg_s1_q;
  reg [2:0] chg_s2_q;
  reg [2:0] chg_prev_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
      chg_s1_q <= 3'h0;
      chg_s2_q <= 3'h0;
      chg_prev_q <= 3'h0;
    end else begin
      ext_s1_q <= ext_irq_pin;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      chg_s1_q <= change_pins;
      chg_s2_q <= chg_s1_q;
      chg_prev_q <= chg_s2_q;
    end
  end

  wire ext_edge = option_q[`IWW_OPT_EDGE] ? (ext_s2_q & ~ext_prev_q) : (~ext_s2_q & ext_prev_q);
  wire chg_evt = |(chg_s2_q ^ chg_prev_q);
  // timer gets no phase clocks while asleep, converter only on its own rc clock
  wire tmr_evt = timer_ovf_evt & ~core_sleeping;
  wire conv_evt = conv_done_evt & (~core_sleeping | conv_rc_clock);

  // ---------------- instruction cycle divider
  reg [1:0] qdiv_q;
  wire q_tick = (qdiv_q == 2'd3);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      qdiv_q <= 2'd0;
    end else begin
      qdiv_q <= qdiv_q + 2'd1;
    end
  end

  // ---------------- ahb-lite register access
  reg wr_pend_q;
  reg [7:0] wr_idx_q;

  function [7:0] idx_of;
    input [31:0] a;
    begin
      idx_of = a[9:2];
    end
  endfunction

  function is_mapped;
    input [7:0] i;
    begin
      is_mapped = (i == `IWW_IDX_STATUS) || (i == `IWW_IDX_IRQ_CONTROL) || (i == `IWW_IDX_PERIPH_FLAG) ||
        (i == `IWW_IDX_OPTION) || (i == `IWW_IDX_PERIPH_ENABLE);
    end
  endfunction

  wire addr_ok = hsel & htrans[1] & hready;
  wire [7:0] a_idx = idx_of(haddr);
  wire a_hit = is_mapped(a_idx) && (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);

  wire wr_ic = wr_pend_q && (wr_idx_q == `IWW_IDX_IRQ_CONTROL);
  wire wr_pf = wr_pend_q && (wr_idx_q == `IWW_IDX_PERIPH_FLAG);
  wire wr_opt = wr_pend_q && (wr_idx_q == `IWW_IDX_OPTION);
  wire wr_pe = wr_pend_q && (wr_idx_q == `IWW_IDX_PERIPH_ENABLE);

  reg [7:0] status_rd;
  reg [7:0] rd_mux;
  always @* begin
    status_rd = 8'h00;
    status_rd[`IWW_ST_TO] = to_q;
    status_rd[`IWW_ST_PD] = pd_q;
    status_rd[`IWW_ST_SLEEP] = core_sleeping;
    case (a_idx)
      `IWW_IDX_STATUS: rd_mux = status_rd;
      `IWW_IDX_IRQ_CONTROL: rd_mux = irq_control_q;
      `IWW_IDX_PERIPH_FLAG: rd_mux = periph_flag_q;
      `IWW_IDX_OPTION: rd_mux = option_q;
      `IWW_IDX_PERIPH_ENABLE: rd_mux = periph_enable_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok & hwrite & a_hit;
      if (addr_ok) begin
        wr_idx_q <= a_idx;
        hrdata <= (!hwrite && a_hit) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
    end
  end

  // ---------------- pending logic
  wire [7:0] ic = irq_control_q;
  wire conv_pend = periph_flag_q[`IWW_PF_CONV] & periph_enable_q[`IWW_PF_CONV] & ic[`IWW_IC_PEIE];
  wire src_pend = (ic[`IWW_IC_TOIF] & ic[`IWW_IC_TOIE]) |
    (ic[`IWW_IC_EXTF] & ic[`IWW_IC_EXTE]) |
    (ic[`IWW_IC_PCF] & ic[`IWW_IC_PCE]) | conv_pend;
  wire irq_req = src_pend & ic[`IWW_IC_GIE];

  // ---------------- watchdog
  reg [22:0] wdt_cnt_q;
  reg [6:0] wdt_post_q;
  wire wdt_on = watchdog_enable_cfg;
  wire wdt_psa = option_q[`IWW_OPT_PSA];
  wire [2:0] wdt_ps = option_q[`IWW_OPT_PS_HI:`IWW_OPT_PS_LO];
  wire base_wrap = (wdt_cnt_q == WDT_BASE_CYC - 23'd1);
  // postscaler ratio is 2**ps when assigned; ratio change without a clear may fire early
  wire post_done = ~wdt_psa || (wdt_post_q == ((7'd1 << wdt_ps) - 7'd1));
  wire wdt_timeout = wdt_on & base_wrap & post_done;
  wire sleep_nop = sleep_instr & src_pend;
  wire sleep_go = sleep_instr & ~src_pend & ~core_sleeping;
  wire wdt_clear = clear_watchdog_instr | sleep_go;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_cnt_q <= 23'd0;
      wdt_post_q <= 7'd0;
    end else if (!wdt_on || wdt_clear || wdt_timeout) begin
      wdt_cnt_q <= 23'd0;
      wdt_post_q <= 7'd0;
    end else if (base_wrap) begin
      wdt_cnt_q <= 23'd0;
      wdt_post_q <= wdt_post_q + 7'd1;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 23'd1;
    end
  end

  // ---------------- sleep state and status bits
  wire wake_src = src_pend | wdt_timeout;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      core_sleeping <= 1'b0;
      wake_pulse <= 1'b0;
      wdt_reset_req <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else begin
      wake_pulse <= 1'b0;
      wdt_reset_req <= 1'b0;
      if (master_reset_pin_evt) begin
        core_sleeping <= 1'b0;
      end else if (core_sleeping) begin
        if (wake_src) begin
          core_sleeping <= 1'b0;
          wake_pulse <= 1'b1;
        end
        if (wdt_timeout) begin
          to_q <= 1'b0;
        end
      end else begin
        if (sleep_go) begin
          core_sleeping <= 1'b1;
          pd_q <= 1'b0;
          to_q <= 1'b1;
        end else if (wdt_timeout) begin
          to_q <= 1'b0;
          pd_q <= 1'b1;
          wdt_reset_req <= 1'b1;
        end else if (clear_watchdog_instr) begin
          to_q <= 1'b1;
          pd_q <= 1'b1;
        end
      end
    end
  end

  assign hold_pins = core_sleeping;
  assign osc_stop = core_sleeping;

  // ---------------- interrupt latency and entry
  reg [1:0] lat_q;
  reg lat_run_q;
  wire take_now = lat_run_q && q_tick && (lat_q == 2'd`IWW_IRQ_LAT_TICKS - 2'd1) && irq_req;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_run_q <= 1'b0;
      lat_q <= 2'd0;
      irq_take <= 1'b0;
      irq_vector <= 13'h0000;
    end else begin
      irq_take <= take_now;
      if (take_now) begin
        irq_vector <= `IWW_VECTOR;
      end
      if (!irq_req || core_sleeping || take_now) begin
        lat_run_q <= 1'b0;
        lat_q <= 2'd0;
      end else if (q_tick) begin
        if (!lat_run_q) begin
          lat_run_q <= 1'b1;
        end else begin
          lat_q <= lat_q + 2'd1;
        end
      end
    end
  end

  // ---------------- register updates; hardware set wins over software clear
  reg [7:0] ic_d;
  always @* begin
    ic_d = irq_control_q;
    if (wr_ic) begin
      ic_d = hwdata[7:0];
    end
    if (return_from_irq_instr) begin
      ic_d[`IWW_IC_GIE] = 1'b1;
    end
    if (take_now || wdt_reset_req || master_reset_pin_evt) begin
      ic_d[`IWW_IC_GIE] = 1'b0;
    end
    if (tmr_evt) begin
      ic_d[`IWW_IC_TOIF] = 1'b1;
    end
    if (ext_edge) begin
      ic_d[`IWW_IC_EXTF] = 1'b1;
    end
    if (chg_evt) begin
      ic_d[`IWW_IC_PCF] = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_control_q <= `IWW_IC_RESET;
      option_q <= `IWW_OPT_RESET;
      periph_flag_q <= `IWW_PF_RESET;
      periph_enable_q <= `IWW_PE_RESET;
    end else begin
      irq_control_q <= ic_d;
      if (wr_opt) begin
        option_q <= hwdata[7:0];
      end
      if (wr_pe) begin
        periph_enable_q <= hwdata[7:0];
      end
      if (conv_evt) begin
        periph_flag_q[`IWW_PF_CONV] <= 1'b1;
      end else if (wr_pf) begin
        periph_flag_q[`IWW_PF_CONV] <= hwdata[`IWW_PF_CONV];
      end
    end
  end

endmodule
`default_nettype wire

//--- iww_ctrl_checker.sv
// port assertions for the interrupt, wake and watchdog block
`timescale 1ns/1ps
`default_nettype none
module iww_ctrl_checker (
  input wire clk,
  input wire rst,
  input wire sleep_instr,
  input wire master_reset_pin_evt,
  input wire watchdog_enable_cfg,
  input wire irq_take,
  input wire [12:0] irq_vector,
  input wire core_sleeping,
  input wire wake_pulse,
  input wire wdt_reset_req,
  input wire hold_pins,
  input wire osc_stop
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_VECTOR: assert property (irq_take |-> irq_vector == 13'h0004) else $error("bad vector");
  AST_TAKE_ONE: assert property (irq_take |=> !irq_take) else $error("long take");
  AST_NO_TAKE_ASLEEP: assert property (core_sleeping |-> !irq_take) else $error("take asleep");
  AST_HOLD: assert property (hold_pins == core_sleeping && osc_stop == core_sleeping) else $error("hold");
  AST_SLEEP_CAUSE: assert property ($rose(core_sleeping) |-> $past(sleep_instr)) else $error("sleep");
  AST_WAKE_EDGE: assert property (wake_pulse |-> $fell(core_sleeping)) else $error("stray wake");
  AST_PIN_RESET: assert property (core_sleeping && master_reset_pin_evt |=> !core_sleeping && !wake_pulse)
    else $error("reset pin");
  AST_WDT_AWAKE: assert property (wdt_reset_req |-> !core_sleeping) else $error("reset asleep");
  AST_WDT_OFF: assert property (!watchdog_enable_cfg |-> !wdt_reset_req) else $error("wdt off");
endmodule
bind iww_ctrl iww_ctrl_checker iww_ctrl_checker_inst (.clk, .rst, .sleep_instr, .master_reset_pin_evt,
  .watchdog_enable_cfg, .irq_take, .irq_vector, .core_sleeping, .wake_pulse, .wdt_reset_req, .hold_pins,
  .osc_stop);
`default_nettype wire

//--- iww_ctrl_partner.sv
// core model: returns from each interrupt after a fixed service time
`timescale 1ns/1ps
`default_nettype none
module iww_ctrl_partner (
  input wire logic clk,
  input wire logic irq_take,
  output var logic return_from_irq_instr
);
  logic [5:0] svc_q = 6'h00;
  initial return_from_irq_instr = 1'b0;
  // long service so the routine can clear its flag before interrupts re-arm
  always @(posedge clk) begin
    return_from_irq_instr <= svc_q == 6'h01;
    if (irq_take)
      svc_q <= 6'h28;
    else if (svc_q != 6'h00)
      svc_q <= svc_q - 6'h01;
  end
endmodule
`default_nettype wire

//--- iww_ctrl_tb.sv
// self-checking bench for the interrupt, wake and watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "iww_ctrl_map.vh"
module iww_ctrl_tb;
  localparam logic [7:0] ic_i = `IWW_IDX_IRQ_CONTROL, st_i = `IWW_IDX_STATUS, op_i = `IWW_IDX_OPTION;
  localparam logic [7:0] pf_i = `IWW_IDX_PERIPH_FLAG, pe_i = `IWW_IDX_PERIPH_ENABLE;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hw = 1'b0, wde = 1'b0, ext = 1'b0;
  logic [4:0] pv = 5'h00;
  logic [2:0] chg = 3'h0;
  logic [1:0] ht = 2'h0;
  logic [31:0] ha = 32'h0000_0000, hwd = 32'h0000_0000, rdat;
  wire [31:0] hrd;
  wire [12:0] vec;
  wire hro, take, slpg, wake, wdr, rfi;
  int n_fail = 0, checks = 0, ntake = 0, nwdr = 0, n, j;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    ntake <= ntake + (take === 1'b1);
    nwdr <= nwdr + (wdr === 1'b1);
  end
  iww_ctrl #(.WDT_BASE_CYC(23'h00_0032)) iww_ctrl_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(ha),
    .htrans(ht), .hwrite(hw), .hsize(3'b010), .hwdata(hwd), .hready(hro), .hrdata(hrd), .hreadyout(hro),
    .hresp(), .return_from_irq_instr(rfi), .clear_watchdog_instr(pv[3]), .sleep_instr(pv[2]),
    .master_reset_pin_evt(pv[4]), .watchdog_enable_cfg(wde), .irq_take(take), .irq_vector(vec),
    .core_sleeping(slpg), .wake_pulse(wake), .wdt_reset_req(wdr), .hold_pins(), .osc_stop(),
    .timer_ovf_evt(pv[0]), .ext_irq_pin(ext), .change_pins(chg), .conv_done_evt(pv[1]), .conv_rc_clock(1'b1));
  iww_ctrl_partner iww_ctrl_partner_inst (.clk(clk), .irq_take(take), .return_from_irq_instr(rfi));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // k: 0 take, 1 wake, 2 watchdog reset, 3 bus ready
  task wev(input int k, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(k == 0 ? take === 1'b1 : k == 1 ? wake === 1'b1 : k == 2 ? wdr === 1'b1 : hro === 1'b1) && n < lim);
    if (n >= lim) begin
      n_fail++;
      summarize;
    end
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    ha <= {22'h00_0000, idx, 2'b00};
    ht <= 2'b10;
    hw <= w;
    wev(3, 20);
    hsel <= 1'b0;
    ht <= 2'b00;
    hwd <= {24'h00_0000, d};
    wev(3, 20);
    rdat = hrd;
  endtask
  task rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, {24'h00_0000, e}, rdat);
  endtask
  task pul(input int b);
    @(posedge clk);
    pv[b] <= 1'b1;
    @(posedge clk);
    pv[b] <= 1'b0;
    // let the design's registered answer settle before anyone looks at it
    @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rc("ic", ic_i, `IWW_IC_RESET);
    rc("opt", op_i, `IWW_OPT_RESET);
    rc("st", st_i, 8'h18);
    rc("unmapped", 8'h40, 8'h00);
    pul(0);
    rc("tmr", ic_i, 8'h04);
    bus(1'b1, ic_i, 8'h00);
    ext <= 1'b1;
    repeat (8) @(posedge clk);
    rc("ext_rise", ic_i, 8'h02);
    bus(1'b1, ic_i, 8'h00);
    bus(1'b1, op_i, 8'hBF);
    ext <= 1'b0;
    repeat (8) @(posedge clk);
    rc("ext_fall", ic_i, 8'h02);
    for (j = 0; j < 3; j++) begin
      bus(1'b1, ic_i, 8'h00);
      chg[j] <= ~chg[j];
      repeat (8) @(posedge clk);
      rc("chg", ic_i, 8'h01);
    end
    bus(1'b1, ic_i, 8'h00);
    pul(1);
    rc("conv", pf_i, 8'h01);
    bus(1'b1, pe_i, 8'h01);
    bus(1'b1, ic_i, 8'h80);
    repeat (30) @(posedge clk);
    chk("no_take", 0, ntake);
    bus(1'b1, ic_i, 8'hC0);
    wev(0, 40);
    chk("vec", `IWW_VECTOR, vec);
    bus(1'b1, pf_i, 8'h00);
    rc("gie_off", ic_i, 8'h40);
    repeat (50) @(posedge clk);
    rc("gie_back", ic_i, 8'hC0);
    chk("takes", 1, ntake);
    bus(1'b1, ic_i, 8'hE0);
    pul(0);
    wev(0, 40);
    chk("latency", 1, n >= 10 && n <= 17);
    bus(1'b1, ic_i, 8'h20);
    repeat (50) @(posedge clk);
    rc("gie_again", ic_i, 8'hA0);
    bus(1'b1, ic_i, 8'h10);
    pul(2);
    chk("asleep", 1, slpg);
    rc("st_sleep", st_i, 8'h11);
    pul(0);
    ext <= 1'b1;
    repeat (10) @(posedge clk);
    chk("still_asleep", 1, slpg);
    ext <= 1'b0;
    wev(1, 20);
    chk("no_vec", 2, ntake);
    rc("st_wake", st_i, 8'h10);
    pul(3);
    pul(2);
    chk("sleep_nop", 0, slpg);
    rc("st_nop", st_i, 8'h18);
    chk("wdt_off", 0, nwdr);
    bus(1'b1, ic_i, 8'h00);
    wde <= 1'b1;
    for (j = 0; j < 2; j++) begin
      pul(3);
      bus(1'b1, op_i, j ? 8'h09 : 8'h00);
      pul(3);
      wev(2, 150);
      chk("wdt_period", 1, n >= 45 + 50 * j && n <= 52 + 50 * j);
    end
    pul(3);
    pul(2);
    wev(1, 150);
    rc("st_wdt_wake", st_i, 8'h00);
    chk("resets", 2, nwdr);
    pul(2);
    pul(4);
    chk("pin_wake", 0, slpg);
    summarize;
  end
endmodule
`default_nettype wire
